// ---- angle_gap.sv ----
/*
 * Forward crank distance from one angle to another, wrapped on the cycle length.
 * Assumes both angles lie below cycle_i.
 */
`timescale 1ns/10ps
module angle_gap
    import injector_pkg::*;
(
    // Angles
    input wire logic [ANGLE_W-1:0] to_i,
    input wire logic [ANGLE_W-1:0] from_i,
    input wire logic [ANGLE_W-1:0] cycle_i,
    // Distance
    output logic [ANGLE_W-1:0] gap_o
);
    logic [ANGLE_W:0] wrapped;

    always_comb begin
        wrapped = {1'b0, to_i} + {1'b0, cycle_i} - {1'b0, from_i};
        if (to_i >= from_i) begin
            gap_o = to_i - from_i;
        end else begin
            gap_o = wrapped[ANGLE_W-1:0];
        end
    end
endmodule

// ---- crank_model.sv ----
/*
 * Crank position tracker model: the angle moves one tick per clock while
 * running, wraps at the cycle length, and a load jumps it anywhere.
 * Assumes it shares the clock and reset of the scheduler.
 */
`timescale 1ns/10ps
module crank_model #(
    parameter logic [15:0] TPC = 16'h3c00
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic run_i,
    input wire logic load_i,
    input wire logic [15:0] load_val_i,
    // Position
    output logic [15:0] angle_o
);
    // Ticks count from tooth zero and wrap at the cycle length
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            angle_o <= 16'h0000;
        end else if (load_i) begin
            angle_o <= load_val_i;
        end else if (run_i) begin
            angle_o <= (angle_o == TPC - 16'h0001) ? 16'h0000 : angle_o + 16'h0001;
        end
    end
endmodule

// ---- injector_pkg.sv ----
/*
 * Shared constants and types for the injector pulse scheduler: register map,
 * control and status bit positions, reset values, tick rates and carriers.
 * Assumes a 100 MHz system clock and a 32-bit classic Wishbone slave port.
 */
package injector_pkg;

    // Clock and tick rates
    localparam int CLK_HZ = 100_000_000;
    localparam int DUR_TICK_HZ = 40_000_000;
    localparam int PEAK_TICK_HZ = 4_000_000;
    localparam int RATE_UNIT_HZ = 1_000_000;
    localparam int DUR_NUM = DUR_TICK_HZ / RATE_UNIT_HZ;
    localparam int DUR_DEN = CLK_HZ / RATE_UNIT_HZ;
    localparam int PEAK_NUM = PEAK_TICK_HZ / RATE_UNIT_HZ;
    localparam int PEAK_DEN = CLK_HZ / RATE_UNIT_HZ;

    // Field widths
    localparam int ANGLE_W = 16;
    localparam int DUR_W = 24;
    localparam int PEAK_W = 8;
    localparam int PEAK_UNIT_SHIFT = 6;
    localparam int PEAK_CNT_W = PEAK_W + PEAK_UNIT_SHIFT;
    localparam int ADR_W = 8;

    // Crank geometry
    localparam logic [21:0] HIST_CAD = 22'h00002d;
    localparam logic [21:0] CAD_TWO_STROKE = 22'h000168;
    localparam logic [21:0] CAD_FOUR_STROKE = 22'h0002d0;

    // Register byte offsets
    localparam logic [ADR_W-1:0] ADR_CTRL = 8'h00;
    localparam logic [ADR_W-1:0] ADR_LEAD = 8'h04;
    localparam logic [ADR_W-1:0] ADR_TRAIL = 8'h08;
    localparam logic [ADR_W-1:0] ADR_STOP = 8'h0c;
    localparam logic [ADR_W-1:0] ADR_PEAK = 8'h10;
    localparam logic [ADR_W-1:0] ADR_DUR = 8'h14;
    localparam logic [ADR_W-1:0] ADR_TPC = 8'h18;
    localparam logic [ADR_W-1:0] ADR_STATUS = 8'h1c;
    localparam logic [ADR_W-1:0] ADR_ANGLE = 8'h20;

    // Control bits
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_TRIGGER = 1;
    localparam int CTRL_FIRE = 2;
    localparam int CTRL_END_VARIANT = 3;
    localparam int CTRL_FOUR_STROKE = 4;
    localparam int CTRL_CUTOFF_CLR = 8;
    localparam int CTRL_SHORT_CLR = 9;

    // Status bits
    localparam int STAT_CUTOFF = 0;
    localparam int STAT_SHORT = 1;
    localparam int STAT_FUEL = 2;
    localparam int STAT_PEAK = 3;
    localparam int STAT_SPENT = 4;

    // Reset values
    localparam logic [ANGLE_W-1:0] TPC_RESET = 16'h3c00;

    typedef enum logic [1:0] {
        SCH_ARMED = 2'b00,
        SCH_PULSE = 2'b01,
        SCH_SPENT = 2'b10
    } sched_state_t;

    typedef struct packed {
        logic enable;
        logic trigger;
        logic fire;
        logic end_variant;
        logic four_stroke;
        logic [ANGLE_W-1:0] lead;
        logic [ANGLE_W-1:0] trail;
        logic [ANGLE_W-1:0] stop;
        logic [PEAK_W-1:0] peak_span;
        logic [31:0] duration;
        logic [ANGLE_W-1:0] ticks_per_cycle;
    } chan_cfg_t;

    typedef struct packed {
        logic fuel_cmd;
        logic peak_sel;
    } drive_cmd_t;

endpackage

// ---- injector_pulse_scheduler.sv ----
/*
 * One channel of crank-angle scheduled fuel injector command generation with a
 * classic Wishbone register slave. Assumes the crank position comes from a
 * tracker on the same clock and the short-circuit sense comes from a pin.
 */
// Decided for this implementation: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
module injector_pulse_scheduler
    import injector_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic stb_i,
    input wire logic cyc_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Position tracker
    input wire logic [ANGLE_W-1:0] present_crank_angle_i,
    // Driver stage
    input wire logic short_detect_i,
    output drive_cmd_t drive_o,
    // Flags
    output logic cutoff_reached_flag_o,
    output logic injector_short_flag_o
);

    typedef struct packed {
        chan_cfg_t cfg;
        sched_state_t sch;
        logic [DUR_W-1:0] acc;
        logic [PEAK_CNT_W-1:0] peak_cnt;
        logic fire_prev;
        logic cutoff_flag;
        logic short_flag;
        logic short_meta;
        logic short_sync;
        logic [ANGLE_W-1:0] last_angle;
        logic [DUR_W-1:0] tick_clks;
        logic [DUR_W-1:0] tick_period;
        logic ack;
        logic [31:0] rdata;
        drive_cmd_t drive;
    } sched_regs_t;

    sched_regs_t st;
    sched_regs_t next_st;

    logic dur_tick;
    logic peak_tick;
    logic [ANGLE_W-1:0] pos;
    logic [ANGLE_W-1:0] lead_behind;
    logic [ANGLE_W-1:0] trail_ahead;
    logic [ANGLE_W-1:0] trail_behind;
    logic [21:0] hist_prod;
    logic [21:0] hist_full;
    logic [ANGLE_W-1:0] hist_ticks;
    logic [39:0] time_to_trail;
    logic [DUR_W-1:0] dur_lim;
    logic hit;
    logic wr;
    logic cut_clr;
    logic short_clr;
    logic run;
    logic fire_edge;
    logic start_hit;
    logic [31:0] m;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction

    rate_tick #(
        .NUM(DUR_NUM),
        .DEN(DUR_DEN)
    ) u_dur_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_o(dur_tick)
    );

    rate_tick #(
        .NUM(PEAK_NUM),
        .DEN(PEAK_DEN)
    ) u_peak_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_o(peak_tick)
    );

    // Same-clock tracker output, read directly every cycle
    assign pos = present_crank_angle_i;

    // Distances are taken forward from one angle to another and wrap at the cycle
    angle_gap u_lead_behind (
        .to_i(pos),
        .from_i(st.cfg.lead),
        .cycle_i(st.cfg.ticks_per_cycle),
        .gap_o(lead_behind)
    );

    angle_gap u_trail_ahead (
        .to_i(st.cfg.trail),
        .from_i(pos),
        .cycle_i(st.cfg.ticks_per_cycle),
        .gap_o(trail_ahead)
    );

    angle_gap u_trail_behind (
        .to_i(pos),
        .from_i(st.cfg.trail),
        .cycle_i(st.cfg.ticks_per_cycle),
        .gap_o(trail_behind)
    );

    always_comb begin
        next_st = st;
        next_st.ack = 1'b0;
        m = '0;

        // 45 degree history window in ticks for the selected stroke count
        hist_prod = 22'(st.cfg.ticks_per_cycle) * HIST_CAD;
        hist_full = hist_prod / (st.cfg.four_stroke ? CAD_FOUR_STROKE : CAD_TWO_STROKE);
        hist_ticks = hist_full[ANGLE_W-1:0];

        dur_lim = st.cfg.duration[DUR_W-1:0];
        time_to_trail = 40'(trail_ahead) * 40'(st.tick_period);

        // Short-circuit sense from the pin
        next_st.short_meta = short_detect_i;
        next_st.short_sync = st.short_meta;

        // Engine speed as 40 MHz ticks per crank tick; saturates when stalled
        next_st.last_angle = pos;
        if (pos != st.last_angle) begin
            next_st.tick_period = st.tick_clks;
            next_st.tick_clks = '0;
        end else if (dur_tick && st.tick_clks != {DUR_W{1'b1}}) begin
            next_st.tick_clks = st.tick_clks + 24'h000001;
        end

        // Bus slave: one wait state, unmapped reads return zero
        hit = cyc_i && stb_i && !st.ack;
        wr = hit && we_i;
        next_st.ack = hit;
        cut_clr = wr && adr_i == ADR_CTRL && sel_i[1] && dat_i[CTRL_CUTOFF_CLR];
        short_clr = wr && adr_i == ADR_CTRL && sel_i[1] && dat_i[CTRL_SHORT_CLR];
        if (wr) begin
            case (adr_i)
                ADR_CTRL: begin
                    m = merge({27'h0000000, st.cfg.four_stroke, st.cfg.end_variant, st.cfg.fire,
                               st.cfg.trigger, st.cfg.enable}, dat_i, sel_i);
                    next_st.cfg.enable = m[CTRL_ENABLE];
                    next_st.cfg.trigger = m[CTRL_TRIGGER];
                    next_st.cfg.fire = m[CTRL_FIRE];
                    next_st.cfg.end_variant = m[CTRL_END_VARIANT];
                    next_st.cfg.four_stroke = m[CTRL_FOUR_STROKE];
                end
                ADR_LEAD: begin
                    m = merge({16'h0000, st.cfg.lead}, dat_i, sel_i);
                    next_st.cfg.lead = m[ANGLE_W-1:0];
                end
                ADR_TRAIL: begin
                    m = merge({16'h0000, st.cfg.trail}, dat_i, sel_i);
                    next_st.cfg.trail = m[ANGLE_W-1:0];
                end
                ADR_STOP: begin
                    m = merge({16'h0000, st.cfg.stop}, dat_i, sel_i);
                    next_st.cfg.stop = m[ANGLE_W-1:0];
                end
                ADR_PEAK: begin
                    m = merge({24'h000000, st.cfg.peak_span}, dat_i, sel_i);
                    next_st.cfg.peak_span = m[PEAK_W-1:0];
                end
                ADR_DUR: begin
                    next_st.cfg.duration = merge(st.cfg.duration, dat_i, sel_i);
                end
                ADR_TPC: begin
                    m = merge({16'h0000, st.cfg.ticks_per_cycle}, dat_i, sel_i);
                    next_st.cfg.ticks_per_cycle = m[ANGLE_W-1:0];
                end
                default: begin
                end
            endcase
        end
        if (hit && !we_i) begin
            case (adr_i)
                ADR_CTRL: next_st.rdata = {27'h0000000, st.cfg.four_stroke, st.cfg.end_variant,
                                           st.cfg.fire, st.cfg.trigger, st.cfg.enable};
                ADR_LEAD: next_st.rdata = {16'h0000, st.cfg.lead};
                ADR_TRAIL: next_st.rdata = {16'h0000, st.cfg.trail};
                ADR_STOP: next_st.rdata = {16'h0000, st.cfg.stop};
                ADR_PEAK: next_st.rdata = {24'h000000, st.cfg.peak_span};
                ADR_DUR: next_st.rdata = st.cfg.duration;
                ADR_TPC: next_st.rdata = {16'h0000, st.cfg.ticks_per_cycle};
                ADR_STATUS: next_st.rdata = {27'h0000000, st.sch == SCH_SPENT, st.drive.peak_sel,
                                             st.drive.fuel_cmd, st.short_flag, st.cutoff_flag};
                ADR_ANGLE: next_st.rdata = {16'h0000, pos};
                default: next_st.rdata = 32'h00000000;
            endcase
        end

        if (cut_clr) begin
            next_st.cutoff_flag = 1'b0;
        end
        if (short_clr) begin
            next_st.short_flag = 1'b0;
        end

        // A live short keeps the channel off until software clears the flag
        run = st.cfg.enable && !st.short_flag;
        fire_edge = st.cfg.fire && !st.fire_prev;
        next_st.fire_prev = st.cfg.fire;

        // Start window covers the exact angle and the late window behind it
        if (st.cfg.end_variant) begin
            start_hit = trail_behind < hist_ticks || time_to_trail <= 40'(dur_lim);
        end else begin
            start_hit = lead_behind < hist_ticks;
        end

        case (st.sch)
            SCH_ARMED: begin
                next_st.acc = '0;
                next_st.peak_cnt = '0;
                if (run && st.cfg.trigger && fire_edge) begin
                    next_st.sch = SCH_PULSE;
                end else if (run && !st.cfg.trigger && start_hit) begin
                    next_st.sch = SCH_PULSE;
                end
            end
            SCH_PULSE: begin
                if (dur_tick) begin
                    next_st.acc = st.acc + 24'h000001;
                end
                if (peak_tick && st.peak_cnt != {PEAK_CNT_W{1'b1}}) begin
                    next_st.peak_cnt = st.peak_cnt + 14'h0001;
                end
                // Duration is re-read each cycle, so edits shorten or extend a live pulse
                if (!run) begin
                    next_st.sch = st.cfg.trigger ? SCH_ARMED : SCH_SPENT;
                end else if (st.acc >= dur_lim) begin
                    next_st.sch = st.cfg.trigger ? SCH_ARMED : SCH_SPENT;
                end
            end
            SCH_SPENT: begin
                next_st.peak_cnt = '0;
            end
            default: begin
                next_st.sch = SCH_ARMED;
            end
        endcase

        // Stop angle wins over everything else in the cycle
        if (pos == st.cfg.stop) begin
            next_st.cutoff_flag = 1'b1;
            next_st.sch = SCH_ARMED;
            next_st.acc = '0;
            next_st.peak_cnt = '0;
        end
        if (st.short_sync) begin
            next_st.short_flag = 1'b1;
        end

        next_st.drive.fuel_cmd = next_st.sch == SCH_PULSE;
        next_st.drive.peak_sel = next_st.drive.fuel_cmd &&
                                 next_st.peak_cnt < {st.cfg.peak_span, 6'h00};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
            st.cfg.ticks_per_cycle <= TPC_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign dat_o = st.rdata;
    assign ack_o = st.ack;
    assign drive_o = st.drive;
    assign cutoff_reached_flag_o = st.cutoff_flag;
    assign injector_short_flag_o = st.short_flag;
endmodule

// ---- injector_pulse_scheduler_sva.sv ----
/*
 * Checker for the injector pulse scheduler ports.
 * Assumes full-word register writes, so a shadow of stop angle and enable
 * can be kept from the bus alone.
 */
`timescale 1ns/10ps
module injector_pulse_scheduler_chk
    import injector_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic we_i,
    input wire logic stb_i,
    input wire logic cyc_i,
    input wire logic ack_o,
    input wire logic [ANGLE_W-1:0] present_crank_angle_i,
    input wire logic short_detect_i,
    input wire drive_cmd_t drive_o,
    input wire logic cutoff_reached_flag_o,
    input wire logic injector_short_flag_o
);
    logic [ANGLE_W-1:0] stop_sh;
    logic en_sh;
    wire wr = cyc_i && stb_i && we_i && !ack_o;
    wire wr_ctrl = wr && adr_i == ADR_CTRL;
    wire at_stop = present_crank_angle_i == stop_sh;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stop_sh <= '0;
            en_sh <= 1'b0;
        end else if (wr) begin
            if (adr_i == ADR_STOP) stop_sh <= dat_i[ANGLE_W-1:0];
            if (adr_i == ADR_CTRL) en_sh <= dat_i[CTRL_ENABLE];
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_after_take_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing after request");
    ack_single_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    cutoff_set_a: assert property (at_stop |=> cutoff_reached_flag_o)
        else $error("cutoff flag not set at stop angle");
    stop_ends_fuel_a: assert property (at_stop |=> !drive_o.fuel_cmd)
        else $error("fuel still on after stop angle");
    enable_gate_a: assert property (!en_sh |=> !drive_o.fuel_cmd)
        else $error("fuel while disabled");
    cutoff_clear_a: assert property (wr_ctrl && dat_i[CTRL_CUTOFF_CLR] && !at_stop |=> !cutoff_reached_flag_o)
        else $error("cutoff flag not cleared");
    short_set_a: assert property (short_detect_i [*3] |=> injector_short_flag_o)
        else $error("short flag not set");
    short_clear_a: assert property (!short_detect_i [*4] ##0 (wr_ctrl && dat_i[CTRL_SHORT_CLR])
        |=> !injector_short_flag_o)
        else $error("short flag not cleared");
    short_gate_a: assert property (injector_short_flag_o |=> !drive_o.fuel_cmd)
        else $error("fuel while short flagged");
    peak_in_fuel_a: assert property (drive_o.peak_sel |-> drive_o.fuel_cmd)
        else $error("peak select outside pulse");

    cover property ($rose(drive_o.fuel_cmd));
    cover property ($rose(cutoff_reached_flag_o));
    cover property ($rose(injector_short_flag_o));
endmodule

// ---- injector_pulse_scheduler_tb_top.sv ----
/*
 * Testbench for the injector pulse scheduler: Wishbone register tasks,
 * crank-driven and immediate pulse scenarios with expected values.
 * Assumes the crank model and the checker are compiled alongside.
 */
`timescale 1ns/10ps
module injector_pulse_scheduler_tb_top
    import injector_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [ADR_W-1:0] adr_i = '0;
    logic [31:0] dat_i = '0;
    logic [3:0] sel_i = '0;
    logic we_i = 1'b0, stb_i = 1'b0, cyc_i = 1'b0, shd = 1'b0;
    logic run = 1'b0, ld = 1'b0;
    logic [15:0] ldv = '0;
    logic [31:0] dat_o, q;
    logic ack_o, cutf, shf;
    logic [ANGLE_W-1:0] crank;
    drive_cmd_t drive_o;
    int err_count = 0, n_compared = 0, n;

    always #5 clk_i = ~clk_i;

    crank_model u_crank (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .load_i(ld), .load_val_i(ldv),
        .angle_o(crank));
    injector_pulse_scheduler u_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
        .sel_i(sel_i), .we_i(we_i), .stb_i(stb_i), .cyc_i(cyc_i), .dat_o(dat_o), .ack_o(ack_o),
        .present_crank_angle_i(crank), .short_detect_i(shd), .drive_o(drive_o),
        .cutoff_reached_flag_o(cutf), .injector_short_flag_o(shf));

    task test_done;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Values are sampled at the edge, before that edge's updates land
    task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        adr_i <= a;
        we_i <= w;
        dat_i <= d;
        sel_i <= 4'hf;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 20);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        if (ack_o !== 1'b1) begin
            err_count++;
            test_done;
        end
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] e);
        wb(a, 1'b0, 32'h0);
        check(q, e);
    endtask

    task wf(input logic lvl, input int lim);
        n = 0;
        while (drive_o.fuel_cmd !== lvl && n < lim) begin
            @(posedge clk_i);
            n++;
        end
    endtask

    task wa(input logic [15:0] p);
        n = 0;
        while (crank !== p && n < 500) begin
            @(posedge clk_i);
            n++;
        end
        check(n < 500, 1);
    endtask

    task goto(input logic [15:0] p);
        @(posedge clk_i);
        ld <= 1'b1;
        ldv <= p;
        @(posedge clk_i);
        ld <= 1'b0;
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(ADR_CTRL, 32'h0);
        rdc(ADR_TPC, {16'h0, TPC_RESET});
        rdc(ADR_LEAD, 32'h0);
        rdc(8'h40, 32'h0);
        rdc(ADR_STATUS, 32'h1);
        goto(16'h0064);
        wb(ADR_CTRL, 1'b1, 32'h100);
        rdc(ADR_STATUS, 32'h0);
        $display("reset and flag clear done");
        // Stop sits well over 45 degrees after every lead used below
        wb(ADR_STOP, 1'b1, 32'hbb8);
        wb(ADR_LEAD, 1'b1, 32'hc8);
        wb(ADR_DUR, 1'b1, 32'h40);
        wb(ADR_PEAK, 1'b1, 32'h1);
        goto(16'h0096);
        run <= 1'b1;
        wf(1'b1, 300);
        check(n, 300);
        run <= 1'b0;
        $display("disabled channel done");
        wb(ADR_DUR, 1'b1, 32'h1000);
        // Park the crank ahead of the lead first, else enabling fires a late pulse
        goto(16'h0096);
        wb(ADR_CTRL, 1'b1, 32'h1);
        run <= 1'b1;
        wa(16'h00c8);
        check(drive_o, 2'b00);
        @(posedge clk_i);
        check(drive_o, 2'b11);
        n = 0;
        while (drive_o.peak_sel === 1'b1 && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        // 64 ticks of 25 clocks, first tick at any phase of the divider
        check(n inside {[1570:1605]}, 1);
        wf(1'b0, 3000);
        check(crank inside {[16'hbb8:16'hbbb]}, 1);
        wb(ADR_STATUS, 1'b0, 32'h0);
        check(q[STAT_CUTOFF], 1);
        wb(ADR_DUR, 1'b1, 32'h0100_0040);
        goto(16'h0096);
        wa(16'h00c8);
        @(posedge clk_i);
        wf(1'b0, 400);
        check(n inside {[158:165]}, 1);
        run <= 1'b0;
        $display("start angle pulses done");
        goto(16'hbb8);
        wb(ADR_LEAD, 1'b1, 32'h1388);
        goto(16'h03e8);
        wb(ADR_LEAD, 1'b1, 32'h384);
        wf(1'b1, 10);
        check(n < 10, 1);
        wf(1'b0, 400);
        goto(16'hbb8);
        goto(16'h1f40);
        wb(ADR_LEAD, 1'b1, 32'h1388);
        wf(1'b1, 300);
        check(n, 300);
        $display("late and skipped pulses done");
        wb(ADR_DUR, 1'b1, 32'h40);
        wb(ADR_CTRL, 1'b1, 32'h3);
        wb(ADR_CTRL, 1'b1, 32'h7);
        wf(1'b1, 10);
        check(n < 10, 1);
        wf(1'b0, 400);
        check(n inside {[158:166]}, 1);
        wf(1'b1, 300);
        check(n, 300);
        wb(ADR_DUR, 1'b1, 32'h1000);
        wb(ADR_CTRL, 1'b1, 32'h3);
        wb(ADR_CTRL, 1'b1, 32'h7);
        wf(1'b1, 10);
        repeat (100) @(posedge clk_i);
        wb(ADR_DUR, 1'b1, 32'h10);
        wf(1'b0, 6);
        check(n < 6, 1);
        $display("immediate pulses done");
        shd <= 1'b1;
        repeat (5) @(posedge clk_i);
        shd <= 1'b0;
        wb(ADR_STATUS, 1'b0, 32'h0);
        check(q[STAT_SHORT], 1);
        wb(ADR_CTRL, 1'b1, 32'h3);
        wb(ADR_CTRL, 1'b1, 32'h7);
        wf(1'b1, 50);
        check(n, 50);
        wb(ADR_CTRL, 1'b1, 32'h203);
        wb(ADR_STATUS, 1'b0, 32'h0);
        check(q[STAT_SHORT], 0);
        $display("short fault done");
        test_done;
    end
endmodule

bind injector_pulse_scheduler injector_pulse_scheduler_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .adr_i(adr_i), .dat_i(dat_i), .we_i(we_i), .stb_i(stb_i), .cyc_i(cyc_i), .ack_o(ack_o),
    .present_crank_angle_i(present_crank_angle_i), .short_detect_i(short_detect_i),
    .drive_o(drive_o), .cutoff_reached_flag_o(cutoff_reached_flag_o),
    .injector_short_flag_o(injector_short_flag_o));

// ---- rate_tick.sv ----
/*
 * Fractional rate divider: emits a one-cycle tick at NUM/DEN of the clock rate.
 * Assumes NUM < DEN and DEN + NUM below 256.
 */
`timescale 1ns/10ps
module rate_tick #(
    parameter int NUM = 1,
    parameter int DEN = 2
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Tick
    output logic tick_o
);
    localparam logic [7:0] NUM8 = 8'(NUM);
    localparam logic [7:0] DEN8 = 8'(DEN);

    typedef struct packed {
        logic [7:0] acc;
        logic tick;
    } tick_state_t;

    tick_state_t st;
    tick_state_t next_st;
    logic [7:0] sum;

    always_comb begin
        next_st = st;
        sum = st.acc + NUM8;
        if (sum >= DEN8) begin
            next_st.acc = sum - DEN8;
            next_st.tick = 1'b1;
        end else begin
            next_st.acc = sum;
            next_st.tick = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick_o = st.tick;
endmodule
